// *** inc/isu_defs.svh ***
// constants of the interrupt, stack and status unit: addresses, bit positions,
// vectors, sizes and reset values. assumes an 8-bit data map and 12-bit pc.
`ifndef ISU_DEFS_SVH
`define ISU_DEFS_SVH

// ----------------------------------------
// data memory map
// ----------------------------------------
`define ISU_ADDR_IND_A 8'h00
`define ISU_ADDR_PTR_A 8'h01
`define ISU_ADDR_IND_B 8'h02
`define ISU_ADDR_PTR_B 8'h03
`define ISU_ADDR_STATUS 8'h0A
`define ISU_ADDR_IRQCTL 8'h0B
`define ISU_ADDR_GPR_LO 8'h60
`define ISU_GPR_COUNT 160

// ----------------------------------------
// flag register fields
// ----------------------------------------
`define ISU_FLG_C 0
`define ISU_FLG_NIB 1
`define ISU_FLG_Z 2
`define ISU_FLG_SX 3
`define ISU_FLG_PWRDN 4
`define ISU_FLG_WDEXP 5

// ----------------------------------------
// interrupt control fields
// ----------------------------------------
`define ISU_INT_GLB 0
`define ISU_INT_EXTEN 1
`define ISU_INT_T0EN 2
`define ISU_INT_T1EN 3
`define ISU_INT_EXTREQ 4
`define ISU_INT_T0REQ 5
`define ISU_INT_T1REQ 6

// ----------------------------------------
// vectors, sizes, reset values
// ----------------------------------------
`define ISU_VEC_EXT 12'h004
`define ISU_VEC_T0 12'h008
`define ISU_VEC_T1 12'h00C
`define ISU_STACK_DEPTH 6
`define ISU_PC_W 12
`define ISU_RST_BYTE 8'h00
`define ISU_RST_PC 12'h000

`endif

// *** inc/isu_pkg.sv ***
// types shared by the unit's modules.
// assumes nothing beyond the constants header.
package isu_pkg;
   typedef enum logic [2:0] {ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_LOGIC, ALU_RLC,
      ALU_RRC} isu_aluop_t;
endpackage

// *** core/isu_flag_alu.sv ***
// arithmetic flag evaluation for the flag register.
// assumes the sequencer presents operands and a logic result on aluB for ALU_LOGIC.
`timescale 1ns/10ps
`include "isu_defs.svh"
module isu_flag_alu
(
   input wire isu_pkg::isu_aluop_t aluOp,
   input wire logic [7:0] aluA,
   input wire logic [7:0] aluB,
   input wire logic carryIn,
   output logic [3:0] flagVal,
   output logic [3:0] flagMask
);

   // returns {excess, zero, nibble carry, carry}; subtraction passes the inverted
   // subtrahend so carry means no borrow
   function automatic logic [3:0] add_flags(input logic [7:0] a, input logic [7:0] b,
      input logic cin);
      logic [4:0] lo;
      logic [7:0] low7;
      logic [8:0] sum;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      low7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
      sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      return {low7[7] ^ sum[8], sum[7:0] == 8'h00, lo[4], sum[8]};
   endfunction

   always_comb
   begin
      flagVal = 4'h0;
      flagMask = 4'hF;
      case (aluOp)
         isu_pkg::ALU_ADD: flagVal = add_flags(aluA, aluB, 1'b0);
         isu_pkg::ALU_ADC: flagVal = add_flags(aluA, aluB, carryIn);
         isu_pkg::ALU_SUB: flagVal = add_flags(aluA, ~aluB, 1'b1);
         isu_pkg::ALU_SBC: flagVal = add_flags(aluA, ~aluB, carryIn);
         isu_pkg::ALU_LOGIC:
         begin
            flagVal[`ISU_FLG_Z] = (aluB == 8'h00);
            flagMask = 4'h4;
         end
         isu_pkg::ALU_RLC:
         begin
            flagVal[`ISU_FLG_C] = aluA[7];
            flagMask = 4'h1;
         end
         isu_pkg::ALU_RRC:
         begin
            flagVal[`ISU_FLG_C] = aluA[0];
            flagMask = 4'h1;
         end
         default: flagMask = 4'h0;
      endcase
   end
endmodule

// *** core/isu_ret_stack.sv ***
// circular return-address stack; a push when full overwrites the oldest entry.
// assumes push and pop never come in the same cycle.
`timescale 1ns/10ps
`include "isu_defs.svh"
module isu_ret_stack
#(
   parameter int DEPTH = `ISU_STACK_DEPTH,
   parameter int WIDTH = `ISU_PC_W
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] pushData,
   output logic [WIDTH-1:0] popData,
   output logic full
);
   localparam int PW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [LW-1:0] TOPLVL = LW'(DEPTH);

   logic [WIDTH-1:0] entries [0:DEPTH-1];
   logic [WIDTH-1:0] next_entries [0:DEPTH-1];
   logic [PW-1:0] headPtr;
   logic [PW-1:0] next_headPtr;
   logic [LW-1:0] level;
   logic [LW-1:0] next_level;
   logic next_full;

   function automatic logic [PW-1:0] wrap_step(input logic [PW-1:0] ptr, input logic up);
      if (up)
         return (ptr == LAST) ? '0 : ptr + 1'b1;
      return (ptr == '0) ? LAST : ptr - 1'b1;
   endfunction

   assign popData = entries[wrap_step(headPtr, 1'b0)];

   always_comb
   begin
      next_entries = entries;
      next_headPtr = headPtr;
      next_level = level;
      if (push)
      begin
         next_entries[headPtr] = pushData;
         next_headPtr = wrap_step(headPtr, 1'b1);
         if (level != TOPLVL)
            next_level = level + 1'b1;
      end
      else if (pop && level != '0)
      begin
         next_headPtr = wrap_step(headPtr, 1'b0);
         next_level = level - 1'b1;
      end
      next_full = (next_level == TOPLVL);
   end

   // reset leaves the index at the top of an empty stack
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
            entries[i] <= '0;
         headPtr <= '0;
         level <= '0;
         full <= 1'b0;
      end
      else
      begin
         entries <= next_entries;
         headPtr <= next_headPtr;
         level <= next_level;
         full <= next_full;
      end
   end

   level_bound_a: assert property (@(posedge clk) disable iff (!arst_n) level <= TOPLVL)
      else $error("stack level above depth");
   full_overwrite_a: assert property (@(posedge clk) disable iff (!arst_n)
      push && full |=> full && level == TOPLVL)
      else $error("push on full stack changed level");
   pop_frees_a: assert property (@(posedge clk) disable iff (!arst_n)
      pop && !push && full |=> !full && level == TOPLVL - 1'b1)
      else $error("pop did not free a level");
endmodule

// *** core/isu_core.sv ***
// interrupt controller, return stack, flag register and data memory window of the core.
// assumes the sequencer pulses one instruction event per cycle and samples outputs next cycle.
//
// Notes on behaviour
// - six-level stack holds pc only, pushed by call or irq, popped by returns.
// - reset puts the stack index at the top of an empty stack.
// - full stack latches requests but delays service until a return frees a level.
// - call on full stack overwrites oldest entry, keeping six newest addresses.
// - addresses 00H and 02H reach memory via pointers; self-pointing reads zero.
// - unused addresses below 60H read zero; general storage spans 60H to FFH.
// - carry flag set on add carry or subtract no-borrow; rotates update it.
// - nibble carry flag set on low nibble carry or no borrow.
// - zero flag set when an arithmetic or logic result is zero.
// - signed excess flag set when carries into and out of msb differ.
// - power-down flag cleared by reset or watchdog clear, set by sleep.
// - watchdog expiry flag cleared by reset, clear or sleep; set on timeout.
// - software writes leave power-down and watchdog expiry flags unchanged.
// - flag bits 6,7 and control bit 7 always read zero.
// - only the pc is saved on entry; flags are not saved.
// - service clears global enable; later requests only set their flags.
// - setting global and source enables inside a handler allows nesting.
// - falling edge on external pin sets bit 4; service vectors to 04H.
// - timer 0 overflow sets bit 5; service vectors to 08H.
// - timer 1 overflow sets bit 6; service vectors to 0CH.
// - control bit 0 global enable, bits 1-3 source enables, one enables.
// - each of the three sources can wake the device from sleep.
// - simultaneous requests served external first, then timer 0, then timer 1.
// - enable-restoring return sets global enable; plain return leaves it.
// - request flags stay set until serviced or cleared by software.
`timescale 1ns/10ps
`include "isu_defs.svh"
module isu_core
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic extIntPin_n,
   input wire logic timer0Ovf,
   input wire logic timer1Ovf,
   input wire logic [11:0] pcNext,
   input wire logic instrBoundary,
   input wire logic callExec,
   input wire logic retExec,
   input wire logic retiExec,
   input wire logic aluWe,
   input wire isu_pkg::isu_aluop_t aluOp,
   input wire logic [7:0] aluA,
   input wire logic [7:0] aluB,
   input wire logic sleepExec,
   input wire logic wdtClearExec,
   input wire logic wdtTimeout,
   input wire logic [7:0] memAddr,
   input wire logic memRd,
   input wire logic memWr,
   input wire logic [7:0] memWdata,
   output logic [7:0] memRdata,
   output logic memRvalid,
   output logic [11:0] retPc,
   output logic retValid,
   output logic irqTaken,
   output logic [11:0] irqVector,
   output logic wakeReq,
   output logic stackFull
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] ptrA;
   logic [7:0] ptrB;
   logic [5:0] flags;
   logic [6:0] irqCtl;
   logic [7:0] gpr [0:`ISU_GPR_COUNT-1];
   logic pinSync1;
   logic pinSync2;
   logic pinPrev;
   logic [7:0] next_ptrA;
   logic [7:0] next_ptrB;
   logic [5:0] next_flags;
   logic [6:0] next_irqCtl;
   logic [7:0] next_gpr [0:`ISU_GPR_COUNT-1];
   logic [7:0] next_memRdata;
   logic [11:0] next_retPc;
   logic [11:0] next_irqVector;
   logic next_wakeReq;

   // ----------------------------------------
   // combinational helpers
   // ----------------------------------------
   logic extFall;
   logic [2:0] pend;
   logic irqTake;
   logic [11:0] popData;
   logic [3:0] aluFlagVal;
   logic [3:0] aluFlagMask;
   logic [8:0] rdTarget;
   logic [8:0] wrTarget;
   logic wrStatus;
   logic wrIrqCtl;

   // resolves the window addresses; bit 8 marks an access that must do nothing
   function automatic logic [8:0] resolve(input logic [7:0] addr, input logic [7:0] pa,
      input logic [7:0] pb);
      logic [7:0] eff;
      eff = addr;
      if (addr == `ISU_ADDR_IND_A)
         eff = pa;
      else if (addr == `ISU_ADDR_IND_B)
         eff = pb;
      if ((addr == `ISU_ADDR_IND_A || addr == `ISU_ADDR_IND_B) &&
         (eff == `ISU_ADDR_IND_A || eff == `ISU_ADDR_IND_B))
         return {1'b1, eff};
      return {1'b0, eff};
   endfunction

   function automatic logic is_gpr(input logic [7:0] addr);
      return addr >= `ISU_ADDR_GPR_LO;
   endfunction

   assign extFall = pinPrev & ~pinSync2;
   assign rdTarget = resolve(memAddr, ptrA, ptrB);
   assign wrTarget = resolve(memAddr, ptrA, ptrB);
   assign wrStatus = memWr && !wrTarget[8] && wrTarget[7:0] == `ISU_ADDR_STATUS;
   assign wrIrqCtl = memWr && !wrTarget[8] && wrTarget[7:0] == `ISU_ADDR_IRQCTL;

   // a pending source needs its flag and its own enable
   assign pend = {irqCtl[`ISU_INT_T1REQ] & irqCtl[`ISU_INT_T1EN],
      irqCtl[`ISU_INT_T0REQ] & irqCtl[`ISU_INT_T0EN],
      irqCtl[`ISU_INT_EXTREQ] & irqCtl[`ISU_INT_EXTEN]};

   // service only at a boundary free of other stack traffic; full stack holds it off
   assign irqTake = instrBoundary && !callExec && !retExec && !retiExec &&
      irqCtl[`ISU_INT_GLB] && (pend != 3'b000) && !stackFull;

   // ----------------------------------------
   // submodules
   // ----------------------------------------
   isu_ret_stack #(.DEPTH(`ISU_STACK_DEPTH), .WIDTH(`ISU_PC_W)) u_stack
   (
      .clk(clk),
      .arst_n(arst_n),
      .push(callExec | irqTake),
      .pop(retExec | retiExec),
      .pushData(pcNext),
      .popData(popData),
      .full(stackFull)
   );

   isu_flag_alu u_flags
   (
      .aluOp(aluOp),
      .aluA(aluA),
      .aluB(aluB),
      .carryIn(flags[`ISU_FLG_C]),
      .flagVal(aluFlagVal),
      .flagMask(aluFlagMask)
   );

   // ----------------------------------------
   // flag register
   // ----------------------------------------
   always_comb
   begin
      next_flags = flags;
      if (aluWe)
      begin
         for (int i = 0; i < 4; i++)
            if (aluFlagMask[i])
               next_flags[i] = aluFlagVal[i];
      end
      // a direct write lands last among the arithmetic bits and never reaches bits 4,5
      if (wrStatus)
         next_flags[3:0] = memWdata[3:0];
      if (sleepExec)
      begin
         next_flags[`ISU_FLG_PWRDN] = 1'b1;
         next_flags[`ISU_FLG_WDEXP] = 1'b0;
      end
      if (wdtClearExec)
      begin
         next_flags[`ISU_FLG_PWRDN] = 1'b0;
         next_flags[`ISU_FLG_WDEXP] = 1'b0;
      end
      // a timeout in the same cycle as a clear must not be lost
      if (wdtTimeout)
         next_flags[`ISU_FLG_WDEXP] = 1'b1;
   end

   // ----------------------------------------
   // interrupt control
   // ----------------------------------------
   always_comb
   begin
      next_irqCtl = irqCtl;
      next_irqVector = irqVector;
      if (wrIrqCtl)
         next_irqCtl = memWdata[6:0];
      if (retiExec)
         next_irqCtl[`ISU_INT_GLB] = 1'b1;
      if (irqTake)
      begin
         next_irqCtl[`ISU_INT_GLB] = 1'b0;
         if (pend[0])
         begin
            next_irqCtl[`ISU_INT_EXTREQ] = 1'b0;
            next_irqVector = `ISU_VEC_EXT;
         end
         else if (pend[1])
         begin
            next_irqCtl[`ISU_INT_T0REQ] = 1'b0;
            next_irqVector = `ISU_VEC_T0;
         end
         else
         begin
            next_irqCtl[`ISU_INT_T1REQ] = 1'b0;
            next_irqVector = `ISU_VEC_T1;
         end
      end
      // new events win over any clear in the same cycle
      if (extFall)
         next_irqCtl[`ISU_INT_EXTREQ] = 1'b1;
      if (timer0Ovf)
         next_irqCtl[`ISU_INT_T0REQ] = 1'b1;
      if (timer1Ovf)
         next_irqCtl[`ISU_INT_T1REQ] = 1'b1;
      // wake does not wait for the global enable, so a disabled handler can still resume
      next_wakeReq = (next_irqCtl[6:4] & next_irqCtl[3:1]) != 3'b000;
      next_retPc = (retExec || retiExec) ? popData : retPc;
   end

   // ----------------------------------------
   // data memory window
   // ----------------------------------------
   always_comb
   begin
      next_ptrA = ptrA;
      next_ptrB = ptrB;
      next_gpr = gpr;
      next_memRdata = memRdata;
      if (memWr && !wrTarget[8])
      begin
         if (wrTarget[7:0] == `ISU_ADDR_PTR_A)
            next_ptrA = memWdata;
         else if (wrTarget[7:0] == `ISU_ADDR_PTR_B)
            next_ptrB = memWdata;
         else if (is_gpr(wrTarget[7:0]))
            next_gpr[wrTarget[7:0] - `ISU_ADDR_GPR_LO] = memWdata;
      end
      if (memRd)
      begin
         next_memRdata = `ISU_RST_BYTE;
         if (!rdTarget[8])
         begin
            if (rdTarget[7:0] == `ISU_ADDR_PTR_A)
               next_memRdata = ptrA;
            else if (rdTarget[7:0] == `ISU_ADDR_PTR_B)
               next_memRdata = ptrB;
            else if (rdTarget[7:0] == `ISU_ADDR_STATUS)
               next_memRdata = {2'b00, flags};
            else if (rdTarget[7:0] == `ISU_ADDR_IRQCTL)
               next_memRdata = {1'b0, irqCtl};
            else if (is_gpr(rdTarget[7:0]))
               next_memRdata = gpr[rdTarget[7:0] - `ISU_ADDR_GPR_LO];
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // the pin idles high, so the edge detector starts high to avoid a false event
         pinSync1 <= 1'b1;
         pinSync2 <= 1'b1;
         pinPrev <= 1'b1;
         ptrA <= `ISU_RST_BYTE;
         ptrB <= `ISU_RST_BYTE;
         flags <= 6'h00;
         irqCtl <= 7'h00;
         for (int i = 0; i < `ISU_GPR_COUNT; i++)
            gpr[i] <= `ISU_RST_BYTE;
         memRdata <= `ISU_RST_BYTE;
         memRvalid <= 1'b0;
         retPc <= `ISU_RST_PC;
         retValid <= 1'b0;
         irqTaken <= 1'b0;
         irqVector <= `ISU_RST_PC;
         wakeReq <= 1'b0;
      end
      else
      begin
         pinSync1 <= extIntPin_n;
         pinSync2 <= pinSync1;
         pinPrev <= pinSync2;
         ptrA <= next_ptrA;
         ptrB <= next_ptrB;
         flags <= next_flags;
         irqCtl <= next_irqCtl;
         gpr <= next_gpr;
         memRdata <= next_memRdata;
         memRvalid <= memRd;
         retPc <= next_retPc;
         retValid <= retExec | retiExec;
         irqTaken <= irqTake;
         irqVector <= next_irqVector;
         wakeReq <= next_wakeReq;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   ext_vector_a: assert property (irqTake && pend[0] |=> irqTaken && irqVector == 12'h004)
      else $error("external service did not vector to 04H");
   t0_vector_a: assert property (irqTake && pend == 3'b010 |=> irqVector == 12'h008)
      else $error("timer 0 service did not vector to 08H");
   prio_order_a: assert property (irqTake && pend == 3'b110 |=> irqVector == 12'h008 &&
      irqCtl[`ISU_INT_T1REQ])
      else $error("priority order violated");
   t1_vector_a: assert property (irqTake && pend == 3'b100 |=> irqVector == 12'h00C)
      else $error("timer 1 service did not vector to 0CH");
   full_blocks_a: assert property (stackFull |=> !irqTaken)
      else $error("service taken on full stack");
   glb_clear_a: assert property (irqTake && !wrIrqCtl |=>
      !irqCtl[`ISU_INT_GLB] && irqTaken)
      else $error("global enable not cleared on service");
   exit_reenable_a: assert property (retiExec && !wrIrqCtl |=>
      irqCtl[`ISU_INT_GLB] && retValid)
      else $error("enable-restoring return left enable clear");
   ret_keeps_a: assert property (retExec && !wrIrqCtl |=>
      irqCtl[`ISU_INT_GLB] == $past(irqCtl[`ISU_INT_GLB]))
      else $error("plain return changed global enable");
   flag_guard_a: assert property (wrStatus && !sleepExec && !wdtClearExec && !wdtTimeout |=>
      flags[5:4] == $past(flags[5:4]))
      else $error("software write changed protected flags");
   timeout_set_a: assert property (wdtTimeout |=> flags[`ISU_FLG_WDEXP])
      else $error("watchdog expiry flag not set");
   sleep_pwrdn_a: assert property (sleepExec && !wdtClearExec |=>
      flags[`ISU_FLG_PWRDN])
      else $error("power-down flag not set by sleep");
   edge_flag_a: assert property (extFall |=> irqCtl[`ISU_INT_EXTREQ] ##1
      (irqCtl[`ISU_INT_EXTREQ] || $past(irqTake || wrIrqCtl)))
      else $error("external request flag lost");
   status_high_a: assert property (memRd && rdTarget == {1'b0, 8'h0A} |=>
      memRvalid && memRdata[7:6] == 2'b00)
      else $error("unused flag bits read nonzero");
   self_window_a: assert property (memRd && rdTarget[8] |=> memRdata == 8'h00)
      else $error("self-pointing window read nonzero");
endmodule

// *** dv/isu_seq_model.sv ***
// sequencer and timer overflow model that drives the core's event inputs.
// assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/10ps
module isu_seq_model
(
   input wire logic clk,
   output logic extIntPin_n,
   output logic timer0Ovf,
   output logic timer1Ovf,
   output logic [11:0] pcNext,
   output logic instrBoundary,
   output logic callExec,
   output logic retExec,
   output logic retiExec,
   output logic aluWe,
   output isu_pkg::isu_aluop_t aluOp,
   output logic [7:0] aluA,
   output logic [7:0] aluB,
   output logic sleepExec,
   output logic wdtClearExec,
   output logic wdtTimeout
);
   // ----------------------------------------
   // event pulses
   // ----------------------------------------
   logic [9:0] ev = 10'h000;
   assign {aluWe, timer0Ovf, timer1Ovf, instrBoundary, callExec, retExec, retiExec, sleepExec,
      wdtClearExec, wdtTimeout} = ev;
   initial
   begin
      extIntPin_n = 1'b1;
      pcNext = 12'h000;
      aluOp = isu_pkg::ALU_ADD;
      aluA = 8'h00;
      aluB = 8'h00;
   end
   // one cycle pulse; operands are scrambled after so stale values are never trusted
   task automatic go(input logic [9:0] e, input logic [11:0] pc);
      @(negedge clk);
      ev = e;
      pcNext = pc;
      @(negedge clk);
      ev = 10'h000;
      pcNext = ~pc;
      aluA = ~aluA;
      aluB = ~aluB;
   endtask
   task automatic alu(input isu_pkg::isu_aluop_t op, input logic [7:0] a, input logic [7:0] b);
      aluOp = op;
      aluA = a;
      aluB = b;
      go(10'h200, pcNext);
   endtask
   // low for three clocks so the synchroniser surely sees the fall
   task automatic pinFall();
      @(negedge clk);
      extIntPin_n = 1'b0;
      repeat (3) @(negedge clk);
      extIntPin_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask
endmodule

// *** dv/isu_core_tb.sv ***
// self-checking bench of the core: register map, flags, interrupts and stack.
// assumes the sequencer model drives events while the bench owns the memory bus.
`timescale 1ns/10ps
module isu_core_tb;
   localparam logic [9:0] T0 = 10'h100, T1 = 10'h080, BND = 10'h040, CAL = 10'h020;
   localparam logic [9:0] XIT = 10'h010, RTI = 10'h008, SLP = 10'h004, WCL = 10'h002;
   localparam logic [9:0] WTO = 10'h001;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] memAddr = 8'h00;
   logic memRd = 1'b0;
   logic memWr = 1'b0;
   logic [7:0] memWdata = 8'h00;
   logic [7:0] memRdata, aluA, aluB;
   logic [11:0] pcNext, retPc, irqVector;
   logic memRvalid, retValid, irqTaken, wakeReq, stackFull, extIntPin_n, timer0Ovf, timer1Ovf;
   logic instrBoundary, callExec, retExec, retiExec, aluWe, sleepExec, wdtClearExec, wdtTimeout;
   isu_pkg::isu_aluop_t aluOp;
   int bad_count = 0;
   int check_count = 0;
   always #25 clk = ~clk;
   isu_seq_model s (.clk, .extIntPin_n, .timer0Ovf, .timer1Ovf, .pcNext, .instrBoundary,
      .callExec, .retExec, .retiExec, .aluWe, .aluOp, .aluA, .aluB, .sleepExec, .wdtClearExec,
      .wdtTimeout);
   isu_core dut (.clk, .arst_n, .extIntPin_n, .timer0Ovf, .timer1Ovf, .pcNext, .instrBoundary,
      .callExec, .retExec, .retiExec, .aluWe, .aluOp, .aluA, .aluB, .sleepExec, .wdtClearExec,
      .wdtTimeout, .memAddr, .memRd, .memWr, .memWdata, .memRdata, .memRvalid, .retPc,
      .retValid, .irqTaken, .irqVector, .wakeReq, .stackFull);
   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] seen);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      memAddr = a;
      memWdata = d;
      memWr = 1'b1;
      @(negedge clk);
      memWr = 1'b0;
      memWdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(negedge clk);
      memAddr = a;
      memRd = 1'b1;
      @(negedge clk);
      memRd = 1'b0;
      chk("memRvalid", 12'h001, {11'h000, memRvalid});
      chk("memRdata", {4'h0, exp}, {4'h0, memRdata & m});
   endtask
   task automatic fl(input isu_pkg::isu_aluop_t op, input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] m, input logic [7:0] exp);
      s.alu(op, a, b);
      rd(8'h0A, m, exp);
   endtask
   task automatic irq(input logic [11:0] pc, input logic t, input logic [11:0] v);
      s.go(BND, pc);
      chk("irqTaken", {11'h000, t}, {11'h000, irqTaken});
      if (t)
         chk("irqVector", v, irqVector);
   endtask
   task automatic rt(input logic [9:0] e, input logic [11:0] exp);
      s.go(e, 12'h000);
      chk("retValid", 12'h001, {11'h000, retValid});
      chk("retPc", exp, retPc);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      #(50 * 3000);
      bad_count++;
      conclude();
   end
   initial
   begin
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      rd(8'h0A, 8'hFF, 8'h00);
      rd(8'h0B, 8'hFF, 8'h00);
      chk("stackFull", 12'h000, {11'h000, stackFull});
      wr(8'h0B, 8'hFF);
      rd(8'h0B, 8'hFF, 8'h7F);
      chk("wakeReq", 12'h001, {11'h000, wakeReq});
      wr(8'h0B, 8'h00);
      wr(8'h0A, 8'hFF);
      rd(8'h0A, 8'hFF, 8'h0F);
      wr(8'h01, 8'h60);
      wr(8'h00, 8'hA5);
      rd(8'h60, 8'hFF, 8'hA5);
      wr(8'h03, 8'h02);
      wr(8'h02, 8'h3C);
      rd(8'h02, 8'hFF, 8'h00);
      wr(8'hFF, 8'h5A);
      wr(8'h20, 8'h77);
      rd(8'h20, 8'hFF, 8'h00);
      rd(8'hFF, 8'hFF, 8'h5A);
      fl(isu_pkg::ALU_ADD, 8'hFF, 8'h01, 8'h0F, 8'h07);
      fl(isu_pkg::ALU_ADC, 8'h00, 8'h00, 8'h0F, 8'h00);
      fl(isu_pkg::ALU_ADD, 8'h7F, 8'h01, 8'h0F, 8'h0A);
      fl(isu_pkg::ALU_SUB, 8'h05, 8'h05, 8'h0F, 8'h07);
      fl(isu_pkg::ALU_SUB, 8'h00, 8'h01, 8'h0F, 8'h00);
      fl(isu_pkg::ALU_LOGIC, 8'h00, 8'h00, 8'h0F, 8'h04);
      fl(isu_pkg::ALU_RLC, 8'h80, 8'h00, 8'h01, 8'h01);
      fl(isu_pkg::ALU_RRC, 8'h00, 8'h00, 8'h01, 8'h00);
      fl(isu_pkg::ALU_SBC, 8'h05, 8'h03, 8'h0F, 8'h03);
      s.go(SLP, 12'h000);
      rd(8'h0A, 8'h30, 8'h10);
      s.go(WTO, 12'h000);
      rd(8'h0A, 8'h30, 8'h30);
      wr(8'h0A, 8'h00);
      rd(8'h0A, 8'h30, 8'h30);
      s.go(WCL, 12'h000);
      rd(8'h0A, 8'h30, 8'h00);
      // masked sources only record their flags
      s.go(T0 | T1, 12'h000);
      s.pinFall();
      rd(8'h0B, 8'hFF, 8'h70);
      chk("wakeReq", 12'h000, {11'h000, wakeReq});
      wr(8'h0B, 8'h7F);
      irq(12'h100, 1'b1, 12'h004);
      rd(8'h0B, 8'hFF, 8'h6E);
      rt(RTI, 12'h100);
      rd(8'h0B, 8'hFF, 8'h6F);
      irq(12'h101, 1'b1, 12'h008);
      irq(12'h102, 1'b0, 12'h000);
      wr(8'h0B, 8'h4F);
      irq(12'h103, 1'b1, 12'h00C);
      rt(XIT, 12'h103);
      rd(8'h0B, 8'hFF, 8'h0E);
      rt(XIT, 12'h101);
      // seven calls on six levels: the first address is lost
      for (int i = 1; i < 8; i++)
         s.go(CAL, 12'(i));
      chk("stackFull", 12'h001, {11'h000, stackFull});
      wr(8'h0B, 8'h25);
      irq(12'h0AA, 1'b0, 12'h000);
      rt(XIT, 12'h007);
      irq(12'h0AA, 1'b1, 12'h008);
      rt(XIT, 12'h0AA);
      for (int i = 6; i > 1; i--)
         rt(XIT, 12'(i));
      conclude();
   end
endmodule
